/* design/mii_phy_port_led_mux.sv */
// Functional notes
// - tx enable rises with first valid nibble, falls after last nibble out.
// - tx nibble per tx clock, bit 3 is most significant.
// - network-side logic runs from the phy tx clock; the code runs it on clk_sys_in, stepping on sampled tx clock rises.
// - collision asynchronous; used only in half duplex.
// - capture rx nibble per rx clock while rx valid high, bit 3 msb.
// - rx valid framing sampled on rising rx clock edge.
// - duplex select low means full duplex, high means half duplex.
// - mii port enabled only for strap codes 0001 or 0010.
// - shared pins are lamps only when strap is 0000.
// - dedicated active-low link lamp, never shared.
// - tx activity lamp low while internal tx pair sends.
// - rx activity lamp low while internal rx pair receives.
// - collision lamp low on collision, half duplex only.
// - duplex lamp low for full duplex, high for half.
// - speed lamp low at 100 Mbps, high at 10 Mbps.
// - dedicated mii inputs pulled down; handled at pad level.
`include "mii_port_cfg.svh"
module mii_phy_port_led_mux
  import mii_port_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic [3:0] strap_mode_in,
  input wire logic mii_txc_in,
  input wire logic mii_rxc_in,
  input wire logic [3:0] mii_rxd_in,
  input wire logic mii_rxdv_in,
  input wire logic mii_crs_in,
  input wire logic mii_col_in,
  input wire logic duplex_select_n_in,
  input wire logic [3:0] tx_data_in,
  input wire logic tx_valid_in,
  output logic tx_ready_out,
  output logic [3:0] rx_data_out,
  output logic rx_valid_out,
  output logic rx_frame_end_out,
  output logic carrier_out,
  output logic collision_out,
  output logic half_duplex_out,
  input wire logic int_link_up_in,
  input wire logic int_tx_active_in,
  input wire logic int_rx_active_in,
  input wire logic int_collision_in,
  input wire logic int_full_duplex_in,
  input wire logic int_speed_100_in,
  output logic link_lamp_n_out,
  output logic mii_txen_tx_lamp_out,
  output logic [3:0] mii_txd_lamps_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  // pins arrive asynchronously; first stage feeds only the second
  logic [6:0] meta_r;
  logic [6:0] sync_r;
  logic [3:0] rxd_meta_r;
  logic [3:0] rxd_sync_r;
  logic [3:0] strap_r;
  wire logic [6:0] raw_pins;
  assign raw_pins = {mii_txc_in, mii_rxc_in, mii_rxdv_in, mii_crs_in, mii_col_in,
    duplex_select_n_in, 1'b0};
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      // zero matches the pad pull-downs, so unused pins read idle
      meta_r <= 7'h00;
      sync_r <= 7'h00;
      rxd_meta_r <= 4'h0;
      rxd_sync_r <= 4'h0;
    end else begin
      meta_r <= raw_pins;
      sync_r <= meta_r;
      rxd_meta_r <= mii_rxd_in;
      rxd_sync_r <= rxd_meta_r;
    end
  end
  wire logic txc_s = sync_r[6];
  wire logic rxc_s = sync_r[5];
  wire logic rxdv_s = sync_r[4];
  wire logic crs_s = sync_r[3];
  wire logic col_s = sync_r[2];
  wire logic dup_sel_s = sync_r[1];

  // strap caught after reset release
  logic strap_taken_r;
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      strap_taken_r <= 1'b0;
      strap_r <= `STRAP_INTERNAL;
    end else if (!strap_taken_r) begin
      strap_taken_r <= 1'b1;
      strap_r <= strap_mode_in;
    end
  end
  wire logic ext_mode = (strap_r == `STRAP_EXT_XTAL) || (strap_r == `STRAP_EXT_OSC);
  wire logic int_mode = (strap_r == `STRAP_INTERNAL);

  // ----------------------------------------
  // link clock edges
  // ----------------------------------------
  logic txc_d_r;
  logic rxc_d_r;
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      txc_d_r <= 1'b0;
      rxc_d_r <= 1'b0;
    end else begin
      txc_d_r <= txc_s;
      rxc_d_r <= rxc_s;
    end
  end
  wire logic txc_rise = txc_s && !txc_d_r;
  wire logic rxc_rise = rxc_s && !rxc_d_r;

  // ----------------------------------------
  // duplex, carrier, collision
  // ----------------------------------------
  wire logic half_dup = dup_sel_s;
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      carrier_out <= 1'b0;
      collision_out <= 1'b0;
      half_duplex_out <= 1'b0;
    end else begin
      carrier_out <= ext_mode && crs_s;
      collision_out <= ext_mode && half_dup && col_s;
      half_duplex_out <= half_dup;
    end
  end

  // ----------------------------------------
  // transmit path
  // ----------------------------------------
  // nibble launched on a tx clock rising edge, held until the next one
  tx_state_t tx_state_r;
  tx_nib_t tx_r;
  wire logic tx_take = ext_mode && txc_rise && tx_valid_in;
  assign tx_ready_out = ext_mode && txc_rise;
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      tx_state_r <= TX_IDLE;
      tx_r <= '0;
    end else if (txc_rise) begin
      case (tx_state_r)
        TX_IDLE: begin
          if (tx_take) begin
            tx_state_r <= TX_SEND;
            tx_r <= '{en: 1'b1, nib: tx_data_in};
          end
        end
        TX_SEND: begin
          if (tx_take) begin
            tx_r <= '{en: 1'b1, nib: tx_data_in};
          end else begin
            tx_state_r <= TX_IDLE;
            tx_r <= '0;
          end
        end
        default: begin
          tx_state_r <= TX_IDLE;
          tx_r <= '0;
        end
      endcase
    end
  end

  // ----------------------------------------
  // receive path
  // ----------------------------------------
  rx_nib_t rx_r;
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      rx_r <= '0;
      rx_data_out <= 4'h0;
      rx_valid_out <= 1'b0;
      rx_frame_end_out <= 1'b0;
    end else begin
      rx_valid_out <= 1'b0;
      rx_frame_end_out <= 1'b0;
      if (ext_mode && rxc_rise) begin
        rx_r <= '{dv: rxdv_s, nib: rxd_sync_r};
        rx_frame_end_out <= rx_r.dv && !rxdv_s;
        if (rxdv_s) begin
          rx_data_out <= rxd_sync_r;
          rx_valid_out <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------
  // lamps and shared pins
  // ----------------------------------------
  // lamp inputs come from the internal phy on this clock: no sync needed
  wire logic [4:0] lamp_bus = {
    int_tx_active_in ? `LAMP_ON : `LAMP_OFF,
    int_rx_active_in ? `LAMP_ON : `LAMP_OFF,
    (int_collision_in && !int_full_duplex_in) ? `LAMP_ON : `LAMP_OFF,
    int_full_duplex_in ? `LAMP_ON : `LAMP_OFF,
    int_speed_100_in ? `LAMP_ON : `LAMP_OFF
  };
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      link_lamp_n_out <= `LAMP_OFF;
      mii_txen_tx_lamp_out <= 1'b0;
      mii_txd_lamps_out <= 4'h0;
    end else begin
      link_lamp_n_out <= int_link_up_in ? `LAMP_ON : `LAMP_OFF;
      if (int_mode) begin
        {mii_txen_tx_lamp_out, mii_txd_lamps_out} <= lamp_bus;
      end else begin
        {mii_txen_tx_lamp_out, mii_txd_lamps_out} <= ext_mode ? tx_r : 5'h00;
      end
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_tx_taken;
    tx_take && tx_state_r == TX_IDLE;
  endsequence
  a_tx_enable_rise: assert property (s_tx_taken |=> ##1 mii_txen_tx_lamp_out)
    else $error("tx enable did not rise");
  a_tx_nib_order: assert property (tx_take |=> ##1 mii_txd_lamps_out == $past(tx_data_in, 2))
    else $error("tx nibble mismatch");
  a_tx_enable_fall: assert property
    (ext_mode && txc_rise && !tx_valid_in |=> ##1 !mii_txen_tx_lamp_out)
    else $error("tx enable did not drop");
  a_col_full_dup: assert property (!half_dup |=> !collision_out)
    else $error("collision seen in full duplex");
  a_rx_capture: assert property (ext_mode && rxc_rise && rxdv_s |=>
    rx_valid_out && rx_data_out == $past(rxd_sync_r))
    else $error("rx nibble not captured");
  a_rx_no_valid: assert property (!rxc_rise |=> !rx_valid_out)
    else $error("rx valid without clock edge");
  a_lamp_int_mode: assert property (strap_taken_r && int_mode |=>
    mii_txd_lamps_out[1] == ($past(int_full_duplex_in) ? `LAMP_ON : `LAMP_OFF))
    else $error("duplex lamp wrong");
  a_speed_lamp: assert property (strap_taken_r && int_mode |=>
    mii_txd_lamps_out[0] == !$past(int_speed_100_in))
    else $error("speed lamp wrong");
  a_link_lamp: assert property (rst_n_in |=> link_lamp_n_out == !$past(int_link_up_in))
    else $error("link lamp wrong");
  a_ext_only_tx: assert property (!ext_mode |-> !tx_ready_out)
    else $error("mii active outside external mode");
  a_rx_quiet_int: assert property (!ext_mode |=>
    !rx_valid_out && !carrier_out && !collision_out)
    else $error("mii status active outside external mode");

  // ----------------------------------------
  // receive framing and status checks
  // ----------------------------------------
  // end of frame is the first rx edge that finds valid low after a high
  sequence s_rx_last;
    ext_mode && rxc_rise && rx_r.dv && !rxdv_s;
  endsequence
  a_rx_frame_end: assert property (s_rx_last |=> rx_frame_end_out)
    else $error("rx frame end missing");
  a_rx_end_only: assert property (!(ext_mode && rxc_rise && rx_r.dv && !rxdv_s) |=>
    !rx_frame_end_out)
    else $error("rx frame end without frame");
  a_carrier_follow: assert property (ext_mode |=> carrier_out == $past(crs_s))
    else $error("carrier sense not passed on");
  a_col_half_dup: assert property (ext_mode && half_dup && col_s |=> collision_out)
    else $error("collision dropped in half duplex");
  a_dup_follow: assert property (rst_n_in |=> half_duplex_out == $past(dup_sel_s))
    else $error("duplex select not passed on");

  // ----------------------------------------
  // transmit hold and lamp checks
  // ----------------------------------------
  // pins may only move two cycles after a detected tx clock rise
  sequence s_tx_gap;
    ext_mode && !txc_rise ##1 ext_mode;
  endsequence
  a_tx_hold: assert property
    (s_tx_gap |=> $stable(mii_txd_lamps_out) && $stable(mii_txen_tx_lamp_out))
    else $error("tx pins moved between tx clock edges");
  sequence s_int_lamps;
    strap_taken_r && int_mode;
  endsequence
  a_tx_lamp: assert property
    (s_int_lamps |=> mii_txen_tx_lamp_out == !$past(int_tx_active_in))
    else $error("tx activity lamp wrong");
  a_rx_lamp: assert property
    (s_int_lamps |=> mii_txd_lamps_out[3] == !$past(int_rx_active_in))
    else $error("rx activity lamp wrong");
  a_col_lamp: assert property
    (s_int_lamps |=> mii_txd_lamps_out[2] ==
      !($past(int_collision_in) && !$past(int_full_duplex_in)))
    else $error("collision lamp wrong");
  // unknown strap codes leave the shared pins parked low
  a_strap_quiet: assert property
    (strap_taken_r && !ext_mode && !int_mode |=> !mii_txen_tx_lamp_out &&
      mii_txd_lamps_out == 4'h0)
    else $error("shared pins driven for unknown strap");
endmodule // mii_phy_port_led_mux

/* pkg/mii_port_cfg.svh */
`ifndef MII_PORT_CFG_SVH
`define MII_PORT_CFG_SVH
// strap codes
`define STRAP_INTERNAL 4'h0
`define STRAP_EXT_XTAL 4'h1
`define STRAP_EXT_OSC 4'h2
// lamp levels
`define LAMP_ON 1'b0
`define LAMP_OFF 1'b1
`endif

/* pkg/mii_port_pkg.sv */
package mii_port_pkg;
  typedef struct packed {
    logic en;
    logic [3:0] nib;
  } tx_nib_t;
  typedef struct packed {
    logic dv;
    logic [3:0] nib;
  } rx_nib_t;
  typedef enum logic [1:0] {
    TX_IDLE,
    TX_SEND
  } tx_state_t;
endpackage

/* tb/phy_model.sv */
// ----------------------------------------
// far-side phy: free clocks, rx frames
// ----------------------------------------
module phy_model (
  output logic txc_out,
  output logic rxc_out,
  output logic [3:0] rxd_out,
  output logic rxdv_out,
  output logic crs_out,
  input wire logic txen_in,
  input wire logic [3:0] txd_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] seen[$];
  initial begin
    rxd_out = 4'h0;
    rxdv_out = 1'b0;
  end
  // odd offsets keep link edges off the system clock edges
  initial begin
    txc_out = 1'b0;
    #7;
    forever #160 txc_out = ~txc_out;
  end
  initial begin
    rxc_out = 1'b0;
    #53;
    forever #160 rxc_out = ~rxc_out;
  end
  assign crs_out = rxdv_out;
  always @(posedge txc_out) if (txen_in === 1'b1) seen.push_back(txd_in);
  task automatic send(input logic [3:0] n[$]);
    foreach (n[i]) begin
      @(negedge rxc_out);
      rxdv_out = 1'b1;
      rxd_out = n[i];
    end
    @(negedge rxc_out);
    rxdv_out = 1'b0;
    // pulled down once released
    rxd_out = 4'h0;
  endtask
endmodule // phy_model

/* tb/tb.sv */
// ----------------------------------------
// bench
// ----------------------------------------
module tb;
  timeunit 1ns;
  timeprecision 1ns;
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin err_count++; \
  $display("wrong value at %0t: %h vs %h", $time, a, e); end end
  logic clk_sys_in = 1'b0, rst_n_in = 1'b0, mii_txc_in, mii_rxc_in, mii_rxdv_in, mii_crs_in;
  logic [3:0] strap_mode_in = 4'h0, mii_rxd_in, tx_data_in = 4'h0, mii_txd_lamps_out, rx_data_out;
  logic mii_col_in = 1'b0, duplex_select_n_in = 1'b0, tx_valid_in = 1'b0;
  logic int_link_up_in = 1'b0, int_tx_active_in = 1'b0, int_rx_active_in = 1'b0;
  logic int_collision_in = 1'b0, int_full_duplex_in = 1'b0, int_speed_100_in = 1'b0;
  logic tx_ready_out, rx_valid_out, rx_frame_end_out, carrier_out, collision_out;
  logic half_duplex_out, link_lamp_n_out, mii_txen_tx_lamp_out;
  logic [3:0] got[$];
  int ends = 0, err_count = 0, checks = 0;
  always #20 clk_sys_in = ~clk_sys_in;
  mii_phy_port_led_mux dut (.clk_sys_in, .rst_n_in, .strap_mode_in, .mii_txc_in, .mii_rxc_in,
    .mii_rxd_in, .mii_rxdv_in, .mii_crs_in, .mii_col_in, .duplex_select_n_in, .tx_data_in,
    .tx_valid_in, .tx_ready_out, .rx_data_out, .rx_valid_out, .rx_frame_end_out,
    .carrier_out, .collision_out, .half_duplex_out, .int_link_up_in, .int_tx_active_in,
    .int_rx_active_in, .int_collision_in, .int_full_duplex_in, .int_speed_100_in,
    .link_lamp_n_out, .mii_txen_tx_lamp_out, .mii_txd_lamps_out);
  phy_model phy (.txc_out(mii_txc_in), .rxc_out(mii_rxc_in), .rxd_out(mii_rxd_in),
    .rxdv_out(mii_rxdv_in), .crs_out(mii_crs_in), .txen_in(mii_txen_tx_lamp_out),
    .txd_in(mii_txd_lamps_out));
  always @(posedge clk_sys_in) begin
    if (rx_valid_out === 1'b1) got.push_back(rx_data_out);
    if (rx_frame_end_out === 1'b1) ends++;
  end
  task automatic start(input logic [3:0] s);
    strap_mode_in <= s;
    rst_n_in <= 1'b0;
    repeat (8) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    repeat (3) @(posedge clk_sys_in);
  endtask
  task automatic tx_frame();
    logic [3:0] d[$] = {4'hA, 4'h5, 4'hC, 4'h3};
    int k = 0;
    int w = 0;
    phy.seen.delete();
    tx_data_in <= d[0];
    tx_valid_in <= 1'b1;
    while (k < 4 && w < 200) begin
      @(posedge clk_sys_in);
      w++;
      if (tx_ready_out === 1'b1) begin
        k++;
        tx_data_in <= d[k % 4];
        if (k == 4) tx_valid_in <= 1'b0;
      end
    end
    repeat (40) @(posedge clk_sys_in);
    `CHK(k, 4)
    `CHK(phy.seen.size(), 4)
    foreach (d[i]) `CHK(phy.seen[i], d[i])
    `CHK(mii_txen_tx_lamp_out, 1'b0)
  endtask
  task automatic rx_frame();
    logic [3:0] d[$] = {4'h1, 4'h8, 4'hE, 4'h6};
    got.delete();
    ends = 0;
    fork
      phy.send(d);
      begin
        repeat (30) @(posedge clk_sys_in);
        `CHK(carrier_out, 1'b1)
      end
    join
    repeat (40) @(posedge clk_sys_in);
    `CHK(got.size(), 4)
    foreach (d[i]) `CHK(got[i], d[i])
    `CHK(ends, 1)
    `CHK(carrier_out, 1'b0)
  endtask
  task automatic col_check();
    for (int h = 0; h < 2; h++) begin
      duplex_select_n_in <= h[0];
      mii_col_in <= 1'b1;
      repeat (6) @(posedge clk_sys_in);
      `CHK(half_duplex_out, h[0])
      `CHK(collision_out, h[0])
      mii_col_in <= 1'b0;
      repeat (6) @(posedge clk_sys_in);
      `CHK(collision_out, 1'b0)
    end
  endtask
  task automatic lamps();
    tx_valid_in <= 1'b1;
    for (logic [6:0] v = 7'h00; v < 7'h40; v++) begin
      {int_link_up_in, int_tx_active_in, int_rx_active_in} <= v[5:3];
      {int_collision_in, int_full_duplex_in, int_speed_100_in} <= v[2:0];
      repeat (4) @(posedge clk_sys_in);
      `CHK(link_lamp_n_out, ~v[5])
      `CHK(mii_txen_tx_lamp_out, ~v[4])
      `CHK(mii_txd_lamps_out, {~v[3], ~(v[2] & ~v[1]), ~v[1], ~v[0]})
      `CHK(tx_ready_out, 1'b0)
    end
    tx_valid_in <= 1'b0;
  endtask
  task automatic other_strap();
    start(4'h3);
    `CHK({mii_txen_tx_lamp_out, mii_txd_lamps_out}, 5'h00)
    `CHK(link_lamp_n_out, ~int_link_up_in)
  endtask
  task automatic finish_test();
    if (err_count == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #200000;
    err_count++;
    finish_test();
  end
  initial begin
    start(4'h1);
    tx_frame();
    rx_frame();
    col_check();
    start(4'h2);
    tx_frame();
    start(4'h0);
    lamps();
    other_strap();
    finish_test();
  end
endmodule // tb
